// >>> rtl/i2c_stat_pkg.sv
package i2c_stat_pkg;

   // register byte addresses on the plain register port
   localparam int unsigned REG_AW = 5;
   localparam logic [4:0] OFS_STATUS = 5'h00;
   localparam logic [4:0] OFS_MASK = 5'h04;
   localparam logic [4:0] OFS_CTRL = 5'h08;
   localparam logic [4:0] OFS_OWN_ADDR = 5'h0c;
   localparam logic [4:0] OFS_TX_HOLD = 5'h10;
   localparam logic [4:0] OFS_RX_HOLD = 5'h14;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h18;
   localparam logic [4:0] OFS_IRQ_MASK = 5'h1c;

   // control register fields
   localparam int unsigned CTRL_W = 4;
   localparam int unsigned CTRL_ENABLE = 0;
   localparam int unsigned CTRL_TEN_BIT = 1;
   localparam int unsigned CTRL_GEN_CALL = 2;
   localparam int unsigned CTRL_MASTER = 3;
   localparam logic [3:0] CTRL_RST = 4'h0;

   // status bits that software may clear by writing a zero
   localparam int unsigned ST_COLL = 10;
   localparam int unsigned ST_WCOL = 7;
   localparam int unsigned ST_OVF = 6;
   localparam int unsigned ST_STOP = 4;
   localparam int unsigned ST_START = 3;

   // interrupt status and mask fields
   localparam int unsigned IRQ_W = 4;
   localparam int unsigned IRQ_START = 0;
   localparam int unsigned IRQ_STOP = 1;
   localparam int unsigned IRQ_BYTE = 2;
   localparam int unsigned IRQ_COLL = 3;
   localparam logic [3:0] IRQ_RST = 4'h0;

   // address matching and reset values
   localparam logic [9:0] MASK_RST = 10'h000;
   localparam logic [9:0] OWN_ADDR_RST = 10'h000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
   localparam logic [4:0] TEN_BIT_HDR = 5'h1e;

   // bit counter positions: counts rising edges of the bus clock line
   localparam logic [3:0] CNT_IDLE = 4'h0;
   localparam logic [3:0] CNT_LAST_DATA = 4'h7;
   localparam logic [3:0] CNT_BYTE_END = 4'h8;
   localparam logic [3:0] CNT_ACK = 4'h9;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_ADDR = 2'b01,
      PH_DATA = 2'b11,
      PH_SKIP = 2'b10
   } phase_t;

   typedef struct packed {
      logic ack_not_received;
      logic master_tx_active;
      logic ack_phase_flag;
      logic [1:0] unused;
      logic collision_flag;
      logic general_call_seen;
      logic ten_bit_match;
      logic write_collision_flag;
      logic receive_overrun_flag;
      logic last_byte_was_data;
      logic stop_seen;
      logic start_seen;
      logic slave_read_direction;
      logic rx_buffer_full;
      logic tx_buffer_full;
   } stat_t;

endpackage : i2c_stat_pkg

// >>> rtl/i2c_status_and_address_mask.sv
// How it works
// - every ninth bus clock rise latches the line level as ack_not_received.
// - master_tx_active is high from byte load until the ninth rise.
// - slave ack_phase_flag sets on eighth fall, clears on ninth rise.
// - collision_flag sets on transmit bus collision, clears when module disabled.
// - general_call_seen sets on accepted general call, clears on stop.
// - ten_bit_match sets on full 10-bit address match, clears on stop.
// - transmit write while busy is dropped and sets write_collision_flag.
// - byte arriving with receive holding still full sets receive_overrun_flag.
// - last_byte_was_data is one after data, zero after an address.
// - stop_seen is one only when stop was the latest bus event.
// - start_seen is one only when start was the latest bus event.
// - slave_read_direction follows the read/write bit of the address.
// - rx_buffer_full sets on stored byte, clears on holding register read.
// - tx_buffer_full holds from write until the byte is shifted out.
// - mask bits set to one exclude that address bit from matching.
// - unused status bits and upper mask bits read as zero.
module i2c_status_and_address_mask
   import i2c_stat_pkg::*;
(
   input wire logic ref_clk, // system clock, 50 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic [4:0] reg_addr, // register byte address
   input wire logic [31:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe, one cycle
   input wire logic reg_rd, // read strobe, one cycle
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   input wire logic scl_i, // bus clock line level
   input wire logic sda_i, // bus data line level
   output logic sda_o, // data line drive value, always low
   output logic sda_oe, // high while pulling data line low
   output logic irq // level interrupt
);

   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   logic scl_d_ff;
   logic sda_d_ff;
   logic scl_s;
   logic sda_s;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   logic [3:0] ctrl_ff;
   logic [9:0] mask_ff;
   logic [9:0] own_addr_ff;
   logic [7:0] tx_hold_ff;
   logic [7:0] rx_hold_ff;
   logic [3:0] irq_stat_ff;
   logic [3:0] irq_mask_ff;
   logic [31:0] rdata_ff;

   phase_t phase_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_in_ff;
   logic [7:0] shift_out_ff;
   logic xmit_ff;
   logic ack_drive_ff;
   logic mtx_ff;
   logic lo_pend_ff;
   logic ten_hi_ff;
   logic slave_rd_ff;
   logic gc_ff;
   logic ten_match_ff;
   logic data_flag_ff;
   logic ack_nr_ff;
   logic ack_phase_ff;
   logic coll_ff;
   logic start_ff;
   logic stop_ff;
   logic rx_full_ff;
   logic ovf_ff;
   logic tx_full_ff;
   logic wcol_ff;

   logic en;
   logic wr_status;
   logic wr_tx;
   logic rd_rx;
   logic busy;
   logic byte_end;
   logic ack_rise;
   logic ack_fall;
   logic addr7_hit;
   logic hdr_hit;
   logic low_hit;
   logic gc_hit;
   logic addr_ok;
   logic rd_sel;
   logic hi_ok;
   logic ten_ok;
   logic gc_ok;
   logic data_in;
   logic addr_byte;
   logic store;
   logic accept;
   logic coll_set;
   logic mtx_load;
   logic stx_load;
   logic [3:0] irq_ev;
   stat_t stat;

   // two flops per pin, third stage only for edge finding
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         scl_sync_ff <= 2'b11;
         sda_sync_ff <= 2'b11;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_sync_ff <= {scl_sync_ff[0], scl_i};
         sda_sync_ff <= {sda_sync_ff[0], sda_i};
         scl_d_ff <= scl_sync_ff[1];
         sda_d_ff <= sda_sync_ff[1];
      end
   end

   // bus conditions seen on the synchronised levels
   assign scl_s = scl_sync_ff[1];
   assign sda_s = sda_sync_ff[1];
   assign scl_rise = en & scl_s & ~scl_d_ff;
   assign scl_fall = en & ~scl_s & scl_d_ff;
   assign start_det = en & scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   assign stop_det = en & scl_s & scl_d_ff & ~sda_d_ff & sda_s;

   // register port decode
   assign en = ctrl_ff[CTRL_ENABLE];
   assign wr_status = reg_wr & (reg_addr == OFS_STATUS);
   assign wr_tx = reg_wr & (reg_addr == OFS_TX_HOLD);
   assign rd_rx = reg_rd & (reg_addr == OFS_RX_HOLD);
   assign busy = tx_full_ff | mtx_ff;

   // bit positions within a byte
   assign byte_end = scl_fall & (bit_cnt_ff == CNT_BYTE_END);
   assign ack_rise = scl_rise & (bit_cnt_ff == CNT_BYTE_END);
   assign ack_fall = scl_fall & (bit_cnt_ff == CNT_ACK);

   // masked compares; a one in the mask means the bit is free
   assign addr7_hit = ((shift_in_ff[7:1] ^ own_addr_ff[6:0]) & ~mask_ff[6:0]) == 7'h00;
   assign hdr_hit = (shift_in_ff[7:3] == TEN_BIT_HDR)
      & (((shift_in_ff[2:1] ^ own_addr_ff[9:8]) & ~mask_ff[9:8]) == 2'h0);
   assign low_hit = ((shift_in_ff ^ own_addr_ff[7:0]) & ~mask_ff[7:0]) == 8'h00;
   assign gc_hit = (shift_in_ff == GEN_CALL_ADDR) & ctrl_ff[CTRL_GEN_CALL];

   // what the completed byte means to the slave
   always_comb begin
      addr_ok = 1'b0;
      rd_sel = 1'b0;
      hi_ok = 1'b0;
      ten_ok = 1'b0;
      gc_ok = 1'b0;
      data_in = 1'b0;
      if (byte_end) begin
         case (phase_ff)
            PH_ADDR: begin
               if (lo_pend_ff) begin
                  ten_ok = low_hit;
               end else if (ctrl_ff[CTRL_TEN_BIT]) begin
                  if (hdr_hit & ~shift_in_ff[0]) begin
                     hi_ok = 1'b1;
                  end else if (hdr_hit & shift_in_ff[0] & ten_hi_ff) begin
                     rd_sel = 1'b1;
                  end else begin
                     gc_ok = gc_hit;
                  end
               end else if (addr7_hit) begin
                  addr_ok = 1'b1;
                  rd_sel = shift_in_ff[0];
               end else begin
                  gc_ok = gc_hit;
               end
            end
            PH_DATA: begin
               data_in = ~slave_rd_ff;
            end
            default: begin
            end
         endcase
      end
   end

   // a byte is only taken, and acked, when the holding register is free
   assign addr_byte = addr_ok | rd_sel | hi_ok | ten_ok | gc_ok;
   assign store = addr_byte | data_in;
   assign accept = store & ~rx_full_ff;
   assign coll_set = scl_rise & xmit_ff & shift_out_ff[7] & ~sda_s;
   assign mtx_load = en & ctrl_ff[CTRL_MASTER] & tx_full_ff & ~mtx_ff & ~scl_s
      & (bit_cnt_ff == CNT_IDLE) & (phase_ff != PH_DATA);
   assign stx_load = ack_fall & (phase_ff == PH_DATA) & slave_rd_ff;

   // bit counter: rising edges since start, wraps after the ack slot
   always_ff @(posedge ref_clk) begin
      if (rst | ~en | start_det | stop_det) begin
         bit_cnt_ff <= CNT_IDLE;
      end else if (scl_rise & (bit_cnt_ff != CNT_ACK)) begin
         bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end else if (ack_fall) begin
         bit_cnt_ff <= CNT_IDLE;
      end
   end

   // receive shifter samples on the first eight rising edges of each byte
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         shift_in_ff <= BYTE_RST;
      end else if (scl_rise & (bit_cnt_ff < CNT_BYTE_END)) begin
         shift_in_ff <= {shift_in_ff[6:0], sda_s};
      end
   end

   // slave phase; the master's own start parks the slave side
   always_ff @(posedge ref_clk) begin
      if (rst | ~en | stop_det) begin
         phase_ff <= PH_IDLE;
         lo_pend_ff <= 1'b0;
         slave_rd_ff <= 1'b0;
      end else if (start_det) begin
         phase_ff <= ctrl_ff[CTRL_MASTER] ? PH_SKIP : PH_ADDR;
         lo_pend_ff <= 1'b0;
      end else if (coll_set) begin
         phase_ff <= PH_SKIP;
      end else if (byte_end & (phase_ff == PH_ADDR)) begin
         if (~accept) begin
            phase_ff <= PH_SKIP;
         end else if (hi_ok) begin
            lo_pend_ff <= 1'b1;
         end else begin
            phase_ff <= PH_DATA;
            lo_pend_ff <= 1'b0;
            slave_rd_ff <= rd_sel;
         end
      end else if (ack_rise & (phase_ff == PH_DATA) & slave_rd_ff & sda_s) begin
         phase_ff <= PH_SKIP; // master refused the byte, stop sending
      end
   end

   // 10-bit header memory survives repeated starts, ends at stop
   always_ff @(posedge ref_clk) begin
      if (rst | ~en | stop_det) begin
         ten_hi_ff <= 1'b0;
         ten_match_ff <= 1'b0;
         gc_ff <= 1'b0;
      end else begin
         if (hi_ok & accept) begin
            ten_hi_ff <= 1'b1;
         end
         if (ten_ok & accept) begin
            ten_match_ff <= 1'b1;
         end
         if (gc_ok & accept) begin
            gc_ff <= 1'b1;
         end
      end
   end

   // transmit shifter for slave reads and master writes
   always_ff @(posedge ref_clk) begin
      if (rst | ~en | start_det | stop_det) begin
         shift_out_ff <= 8'hff;
         xmit_ff <= 1'b0;
      end else if (coll_set | byte_end) begin
         xmit_ff <= 1'b0; // release the line for the ack slot
         shift_out_ff <= 8'hff;
      end else if (mtx_load | stx_load) begin
         shift_out_ff <= tx_hold_ff;
         xmit_ff <= 1'b1;
      end else if (scl_fall & xmit_ff & (bit_cnt_ff <= CNT_LAST_DATA)) begin
         shift_out_ff <= {shift_out_ff[6:0], 1'b1};
      end
   end

   // master byte in flight, until the rise of its ack slot
   always_ff @(posedge ref_clk) begin
      if (rst | ~en | stop_det | coll_set) begin
         mtx_ff <= 1'b0;
      end else if (mtx_load) begin
         mtx_ff <= 1'b1;
      end else if (ack_rise) begin
         mtx_ff <= 1'b0;
      end
   end

   // our ack pulse runs from eighth fall to ninth fall
   always_ff @(posedge ref_clk) begin
      if (rst | ~en | start_det | stop_det) begin
         ack_drive_ff <= 1'b0;
      end else if (byte_end) begin
         ack_drive_ff <= accept;
      end else if (ack_fall) begin
         ack_drive_ff <= 1'b0;
      end
   end

   // ack outcome and ack window flags
   always_ff @(posedge ref_clk) begin
      if (rst | ~en) begin
         ack_nr_ff <= 1'b0;
         ack_phase_ff <= 1'b0;
      end else begin
         if (ack_rise) begin
            ack_nr_ff <= sda_s;
         end
         if (byte_end & ((phase_ff == PH_ADDR) | (phase_ff == PH_DATA))) begin
            ack_phase_ff <= 1'b1;
         end else if (ack_rise | start_det | stop_det) begin
            ack_phase_ff <= 1'b0;
         end
      end
   end

   // data versus address of the last byte taken
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         data_flag_ff <= 1'b0;
      end else if (addr_byte & accept) begin
         data_flag_ff <= 1'b0;
      end else if (data_in & accept) begin
         data_flag_ff <= 1'b1;
      end
   end

   // collision is sticky until disable or a zero write; set wins
   always_ff @(posedge ref_clk) begin
      if (rst | ~en) begin
         coll_ff <= 1'b0;
      end else if (coll_set) begin
         coll_ff <= 1'b1;
      end else if (wr_status & ~reg_wdata[ST_COLL]) begin
         coll_ff <= 1'b0;
      end
   end

   // latest bus condition; detection beats a software clear
   always_ff @(posedge ref_clk) begin
      if (rst | ~en) begin
         start_ff <= 1'b0;
         stop_ff <= 1'b0;
      end else if (start_det) begin
         start_ff <= 1'b1;
         stop_ff <= 1'b0;
      end else if (stop_det) begin
         start_ff <= 1'b0;
         stop_ff <= 1'b1;
      end else if (wr_status) begin
         start_ff <= start_ff & reg_wdata[ST_START];
         stop_ff <= stop_ff & reg_wdata[ST_STOP];
      end
   end

   // receive holding; a held byte is never overwritten
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rx_hold_ff <= BYTE_RST;
         rx_full_ff <= 1'b0;
      end else if (accept) begin
         rx_hold_ff <= shift_in_ff;
         rx_full_ff <= 1'b1;
      end else if (rd_rx) begin
         rx_full_ff <= 1'b0;
      end
   end

   // overrun is sticky; the event beats a same-cycle clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ovf_ff <= 1'b0;
      end else if (store & rx_full_ff) begin
         ovf_ff <= 1'b1;
      end else if (wr_status & ~reg_wdata[ST_OVF]) begin
         ovf_ff <= 1'b0;
      end
   end

   // transmit holding; a write while busy is dropped
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_hold_ff <= BYTE_RST;
         tx_full_ff <= 1'b0;
      end else if (wr_tx & ~busy) begin
         tx_hold_ff <= reg_wdata[7:0];
         tx_full_ff <= 1'b1;
      end else if (byte_end & xmit_ff) begin
         tx_full_ff <= 1'b0;
      end
   end

   // write collision is sticky; the event beats a same-cycle clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wcol_ff <= 1'b0;
      end else if (wr_tx & busy) begin
         wcol_ff <= 1'b1;
      end else if (wr_status & ~reg_wdata[ST_WCOL]) begin
         wcol_ff <= 1'b0;
      end
   end

   // software configuration registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_ff <= CTRL_RST;
         mask_ff <= MASK_RST;
         own_addr_ff <= OWN_ADDR_RST;
         irq_mask_ff <= IRQ_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            OFS_CTRL: ctrl_ff <= reg_wdata[3:0];
            OFS_MASK: mask_ff <= reg_wdata[9:0];
            OFS_OWN_ADDR: own_addr_ff <= reg_wdata[9:0];
            OFS_IRQ_MASK: irq_mask_ff <= reg_wdata[3:0];
            default: begin
            end
         endcase
      end
   end

   // interrupt status: write one to clear, a new event wins
   assign irq_ev = {coll_set, byte_end & (addr_byte | data_in | xmit_ff), stop_det, start_det};
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_stat_ff <= IRQ_RST;
      end else if (reg_wr & (reg_addr == OFS_IRQ_STAT)) begin
         irq_stat_ff <= (irq_stat_ff & ~reg_wdata[3:0]) | irq_ev;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_ev;
      end
   end

   // status word as software sees it
   always_comb begin
      stat = '0;
      stat.ack_not_received = ack_nr_ff;
      stat.master_tx_active = mtx_ff;
      stat.ack_phase_flag = ack_phase_ff;
      stat.unused = 2'b00;
      stat.collision_flag = coll_ff;
      stat.general_call_seen = gc_ff;
      stat.ten_bit_match = ten_match_ff;
      stat.write_collision_flag = wcol_ff;
      stat.receive_overrun_flag = ovf_ff;
      stat.last_byte_was_data = data_flag_ff;
      stat.stop_seen = stop_ff;
      stat.start_seen = start_ff;
      stat.slave_read_direction = slave_rd_ff;
      stat.rx_buffer_full = rx_full_ff;
      stat.tx_buffer_full = tx_full_ff;
   end

   // registered read data; unmapped addresses read zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            OFS_STATUS: rdata_ff <= {16'h0000, stat};
            OFS_MASK: rdata_ff <= {22'h00_0000, mask_ff};
            OFS_CTRL: rdata_ff <= {28'h000_0000, ctrl_ff};
            OFS_OWN_ADDR: rdata_ff <= {22'h00_0000, own_addr_ff};
            OFS_TX_HOLD: rdata_ff <= {24'h00_0000, tx_hold_ff};
            OFS_RX_HOLD: rdata_ff <= {24'h00_0000, rx_hold_ff};
            OFS_IRQ_STAT: rdata_ff <= {28'h000_0000, irq_stat_ff};
            OFS_IRQ_MASK: rdata_ff <= {28'h000_0000, irq_mask_ff};
            default: rdata_ff <= 32'h0000_0000;
         endcase
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   // open-drain data line: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe = (xmit_ff & ~shift_out_ff[7]) | ack_drive_ff;
   assign reg_rdata = rdata_ff;
   assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule : i2c_status_and_address_mask

// >>> bench/i2c_stat_asserts.sv
module i2c_stat_asserts
   import i2c_stat_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic [4:0] reg_addr, // register address
   input wire logic [31:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [31:0] reg_rdata, // read data
   input wire logic scl_i, // bus clock line
   input wire logic sda_i, // bus data line
   input wire logic sda_o, // data drive value
   input wire logic sda_oe, // data drive enable
   input wire logic irq // interrupt level
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // read data only in the answer cycle, so stale words never leak out
   a_rdata_idle_zero:
      assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data not zero outside answer cycle");
   a_mask_upper_zero:
      assert property ($past(reg_rd) && $past(reg_addr) == OFS_MASK |-> reg_rdata[31:10] == 22'h00_0000)
      else $error("upper mask bits not zero");
   a_stat_unused_zero:
      assert property ($past(reg_rd) && $past(reg_addr) == OFS_STATUS
         |-> reg_rdata[31:16] == 16'h0000 && reg_rdata[12:11] == 2'h0)
      else $error("unused status bits not zero");
   a_start_stop_excl:
      assert property ($past(reg_rd) && $past(reg_addr) == OFS_STATUS
         |-> !(reg_rdata[ST_STOP] && reg_rdata[ST_START]))
      else $error("start and stop both shown as latest");
   a_disable_clears:
      assert property (reg_wr && reg_addr == OFS_CTRL && !reg_wdata[CTRL_ENABLE]
         ##2 reg_rd && reg_addr == OFS_STATUS
         |=> reg_rdata[ST_COLL] == 1'b0 && reg_rdata[ST_STOP:ST_START] == 2'h0)
      else $error("disable left bus event flags set");
   a_rx_read_empties:
      assert property (reg_rd && reg_addr == OFS_RX_HOLD ##2 reg_rd && reg_addr == OFS_STATUS
         |=> !reg_rdata[1])
      else $error("receive full survived holding read");
   a_zero_write_clears:
      assert property (reg_wr && reg_addr == OFS_STATUS ##2 reg_rd && reg_addr == OFS_STATUS
         |=> (reg_rdata[7:6] & ~$past(reg_wdata[7:6], 3)) == 2'h0)
      else $error("zero write did not clear sticky flag");
   a_irq_masked_low:
      assert property (reg_wr && reg_addr == OFS_IRQ_MASK && reg_wdata[3:0] == 4'h0 |=> !irq[*2])
      else $error("interrupt high with all sources masked");
endmodule : i2c_stat_asserts

bind i2c_status_and_address_mask i2c_stat_asserts u_chk (.ref_clk(ref_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
   .irq(irq));

// >>> bench/bus_host_model.sv
module bus_host_model (
   output logic scl, // bus clock line, idles high
   output logic sda_drv, // data drive, one releases to pull-up
   input wire logic sda_w // resolved data line level
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle bus: both lines released
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // long low half keeps our data change clear of the slave's late release
   task automatic bit_cell(input logic b, output logic s);
      #40 sda_drv = b;
      #60 scl = 1'b1;
      #30 s = sda_w;
      #30 scl = 1'b0;
   endtask : bit_cell

   // data falls while the clock is high
   task automatic start_cond;
      #40 sda_drv = 1'b1;
      #40 scl = 1'b1;
      #40 sda_drv = 1'b0;
      #40 scl = 1'b0;
   endtask : start_cond

   // data rises while the clock is high
   task automatic stop_cond;
      #40 sda_drv = 1'b0;
      #60 scl = 1'b1;
      #40 sda_drv = 1'b1;
   endtask : stop_cond

   // msb first, then sample the slave's answer
   task automatic send_byte(input logic [7:0] b, output logic nack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cell(b[i], s);
      end
      bit_cell(1'b1, nack);
   endtask : send_byte

   // released line lets the slave shift its byte out
   task automatic get_byte(input logic nack, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cell(1'b1, b[i]);
      end
      bit_cell(nack, s);
   endtask : get_byte
endmodule : bus_host_model

// >>> bench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import i2c_stat_pkg::*;

   logic ref_clk, rst, reg_wr, reg_rd, sda_o, sda_oe, irq, scl, sda_drv, n;
   logic [4:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic [7:0] db, b;
   logic [6:0] own, ab;
   logic [9:0] amask;
   int err_total, checks, cyc;
   integer seed;
   wire logic sda_w = sda_drv & ~sda_oe; // pull-up unless someone pulls low

   i2c_status_and_address_mask dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
   bus_host_model m (.scl(scl), .sda_drv(sda_drv), .sda_w(sda_w));

   // 50 MHz system clock
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic report_and_stop;
      if (err_total == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop

   // hang guard, far above the roughly one thousand cycles expected
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one-cycle strobes launched just after an edge
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd

   task automatic st(input logic [15:0] mk, input logic [15:0] e);
      rd(OFS_STATUS, d);
      chk(d & {16'h0000, mk}, {16'h0000, e});
   endtask : st

   // lets the synchronisers catch up with a bus condition
   task automatic gap;
      repeat (8) @(posedge ref_clk);
   endtask : gap

   // own address with the masked positions scrambled
   function automatic logic [6:0] masked_addr(input logic [6:0] a, input logic [9:0] mk,
      input logic [6:0] r);
      return a ^ (r & mk[6:0]);
   endfunction : masked_addr

   initial begin
      seed = 32'h3cda_8bca;
      rst = 1'b1;
      reg_addr = 5'h00;
      reg_wdata = 32'h0000_0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      rd(OFS_STATUS, d);
      chk(d, 32'h0000_0000);
      wr(OFS_MASK, 32'hffff_ffff);
      rd(OFS_MASK, d);
      chk(d, 32'h0000_03ff);
      rd(5'h13, d);
      chk(d, 32'h0000_0000);
      own = 7'h20 | (7'($random(seed)) & 7'h17);
      amask = 10'($random(seed)) & 10'h01f;
      ab = masked_addr(own, amask, 7'($random(seed)));
      wr(OFS_OWN_ADDR, {25'h000_0000, own});
      wr(OFS_MASK, {22'h00_0000, amask});
      wr(OFS_CTRL, 32'h0000_0005);
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      // masked address accepted, then a byte into a full holding register
      m.start_cond;
      gap;
      chk(32'(irq), 32'h0000_0001);
      st(16'h0018, 16'h0008);
      wr(OFS_IRQ_STAT, 32'h0000_0001);
      #1 chk(32'(irq), 32'h0000_0000);
      m.send_byte({ab, 1'b0}, n);
      chk(32'(n), 32'h0000_0000);
      st(16'ha026, 16'h0002);
      rd(OFS_RX_HOLD, d);
      chk(d, {24'h00_0000, ab, 1'b0});
      st(16'h0002, 16'h0000);
      db = 8'($random(seed));
      m.send_byte(db, n);
      st(16'h8022, 16'h0022);
      m.send_byte(~db, n);
      chk(32'(n), 32'h0000_0001);
      st(16'h8040, 16'h8040);
      wr(OFS_STATUS, 32'h0000_ffff);
      st(16'h0040, 16'h0040);
      wr(OFS_STATUS, 32'h0000_ffbf);
      st(16'h0040, 16'h0000);
      rd(OFS_RX_HOLD, d);
      chk(d, {24'h00_0000, db});
      m.stop_cond;
      gap;
      st(16'h0018, 16'h0010);
      // unmasked bit wrong, then general call until stop
      m.start_cond;
      m.send_byte({own ^ 7'h40, 1'b0}, n);
      chk(32'(n), 32'h0000_0001);
      m.stop_cond;
      m.start_cond;
      m.send_byte(8'h00, n);
      chk(32'(n), 32'h0000_0000);
      st(16'h0200, 16'h0200);
      rd(OFS_RX_HOLD, d);
      m.stop_cond;
      gap;
      st(16'h0200, 16'h0000);
      // second transmit write dropped; slave read returns the first
      db = 8'($random(seed));
      wr(OFS_TX_HOLD, {24'h00_0000, db});
      wr(OFS_TX_HOLD, {24'h00_0000, ~db});
      st(16'h0081, 16'h0081);
      m.start_cond;
      m.send_byte({ab, 1'b1}, n);
      st(16'h0004, 16'h0004);
      rd(OFS_RX_HOLD, d);
      m.get_byte(1'b1, b);
      chk({24'h00_0000, b}, {24'h00_0000, db});
      st(16'h0001, 16'h0000);
      m.stop_cond;
      wr(OFS_STATUS, 32'h0000_ff7f);
      st(16'h0080, 16'h0000);
      // collision on a slave one, then master mode sends it
      wr(OFS_TX_HOLD, 32'h0000_00a5);
      m.start_cond;
      m.send_byte({ab, 1'b1}, n);
      m.bit_cell(1'b0, n);
      st(16'h0400, 16'h0400);
      m.stop_cond;
      wr(OFS_CTRL, 32'h0000_0009);
      m.start_cond;
      gap;
      st(16'h4000, 16'h4000);
      m.get_byte(1'b0, b);
      chk({24'h00_0000, b}, 32'h0000_00a5);
      st(16'h4001, 16'h0000);
      m.stop_cond;
      // ten-bit header, then the low byte
      wr(OFS_CTRL, 32'h0000_0003);
      rd(OFS_RX_HOLD, d);
      m.start_cond;
      m.send_byte(8'hf0, n);
      rd(OFS_RX_HOLD, d);
      m.send_byte({1'b0, own}, n);
      st(16'h0100, 16'h0100);
      m.stop_cond;
      // disable drops bus event flags; masked interrupt stays low
      wr(OFS_CTRL, 32'h0000_0000);
      st(16'h0418, 16'h0000);
      wr(OFS_IRQ_MASK, 32'h0000_0000);
      #1 chk(32'(irq), 32'h0000_0000);
      report_and_stop();
   end
endmodule : testbench
